//--- rtl/drive_control_word_decoder.sv
`timescale 1ns/1ps
`default_nettype none
`include "dcw_defs.svh"
module drive_control_word_decoder (
    input wire logic core_clk,
    input wire logic rst_n,
    // client side register writes
    input wire logic cmd_wr,
    input wire logic [15:0] cmd_wdata,
    input wire logic ref1_wr,
    input wire logic [15:0] ref1_wdata,
    input wire logic ref2_wr,
    input wire logic [15:0] ref2_wdata,
    // configuration
    input wire dcw_pkg::profile_t profile_sel,
    input wire logic [1:0] map_sel,
    input wire logic run_permit_from_bus,
    input wire logic run_permit_ext,
    input wire logic [15:0] primary_setpoint_full_scale,
    input wire logic [15:0] secondary_setpoint_full_scale,
    input wire logic [15:0] setpoint_floor,
    input wire logic setpoint_floor_en,
    input wire logic [1:0] actual_sel,
    // drive side
    input wire logic fault_in,
    input wire logic [15:0] actual_a,
    input wire logic [15:0] actual_b,
    input wire logic [15:0] actual_c,
    input wire logic [15:0] actual_d,
    input wire dcw_pkg::drive_in_t drive_native_in,
    output dcw_pkg::drive_out_t drive_native_format,
    output logic [15:0] status_word,
    output logic [15:0] actual_word,
    output logic [15:0] ramp_out,
    output logic [1:0] map_active,
    output logic ramp_stop_cmd,
    output logic coast_stop_cmd,
    output logic quick_stop_cmd
);
    import dcw_pkg::*;

    typedef enum logic [2:0] {
        st_inhibit,
        st_rdy_on,
        st_rdy_run,
        st_op_en,
        st_ramp_stop,
        st_coast_stop,
        st_quick_stop,
        st_fault
    } drive_state_t;

    drive_state_t state_q, state_d;
    logic [15:0] cmd_q;
    logic [15:0] ref1_q;
    logic [15:0] ref2_q;
    logic reset_bit_q;
    logic fault_s1_q, fault_s2_q;
    logic [15:0] ramp_q, ramp_d;
    logic [15:0] ref1_scaled, ref2_scaled;
    logic [15:0] status_d;
    logic [15:0] actual_d_w;
    logic run_permit;
    logic fault_reset;
    drive_out_t native_d;

    // decoded stop requests, active low in the command word
    function automatic logic stop_req(input logic [15:0] w, input int b);
        return ~w[b];
    endfunction : stop_req

    // the external fault comes from another domain, so synchronise it
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            fault_s1_q <= 1'b0;
            fault_s2_q <= 1'b0;
        end else begin
            fault_s1_q <= fault_in;
            fault_s2_q <= fault_s1_q;
        end
    end

    // client writes land in the word registers
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cmd_q <= `CMD_WORD_RESET;
            ref1_q <= 16'h0000;
            ref2_q <= 16'h0000;
        end else begin
            if (cmd_wr) cmd_q <= cmd_wdata;
            if (ref1_wr) ref1_q <= ref1_wdata;
            if (ref2_wr) ref2_q <= ref2_wdata;
        end
    end

    // previous reset bit for edge detection
    always_ff @(posedge core_clk) begin
        if (!rst_n) reset_bit_q <= 1'b0;
        else reset_bit_q <= cmd_q[`CMD_FAULT_RESET_BIT];
    end

    assign fault_reset = cmd_q[`CMD_FAULT_RESET_BIT] & ~reset_bit_q;
    // run permit from the bus bit or an external source
    assign run_permit = run_permit_from_bus ? cmd_q[`CMD_RUN_PERMIT_BIT] : run_permit_ext;

    // drive state machine
    always_comb begin
        state_d = state_q;
        case (state_q)
            st_fault: begin
                if (fault_reset && !fault_s2_q) state_d = st_inhibit;
            end
            st_coast_stop: begin
                if (ramp_q == 16'h0000) state_d = st_inhibit;
            end
            st_quick_stop: begin
                if (ramp_q == 16'h0000) state_d = st_inhibit;
            end
            st_ramp_stop: begin
                if (stop_req(cmd_q, `CMD_COAST_STOP_BIT)) state_d = st_coast_stop;
                else if (stop_req(cmd_q, `CMD_QUICK_STOP_BIT)) state_d = st_quick_stop;
                else if (ramp_q == 16'h0000) state_d = st_rdy_on;
            end
            st_inhibit: begin
                // leave only once coast and quick stop are released and bit 0 is low
                if (!stop_req(cmd_q, `CMD_COAST_STOP_BIT) &&
                    !stop_req(cmd_q, `CMD_QUICK_STOP_BIT) &&
                    stop_req(cmd_q, `CMD_RAMP_STOP_BIT)) state_d = st_rdy_on;
            end
            st_rdy_on: begin
                if (stop_req(cmd_q, `CMD_COAST_STOP_BIT) ||
                    stop_req(cmd_q, `CMD_QUICK_STOP_BIT)) state_d = st_inhibit;
                else if (!stop_req(cmd_q, `CMD_RAMP_STOP_BIT)) state_d = st_rdy_run;
            end
            st_rdy_run, st_op_en: begin
                if (stop_req(cmd_q, `CMD_COAST_STOP_BIT)) state_d = st_coast_stop;
                else if (stop_req(cmd_q, `CMD_QUICK_STOP_BIT)) state_d = st_quick_stop;
                else if (stop_req(cmd_q, `CMD_RAMP_STOP_BIT)) state_d = st_ramp_stop;
                else if (cmd_q[`CMD_RUN_PERMIT_BIT] && run_permit) state_d = st_op_en;
                else state_d = st_rdy_run;
            end
            default: state_d = st_inhibit;
        endcase
        // a live fault overrides every other state
        if (fault_s2_q) state_d = st_fault;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) state_q <= st_inhibit;
        else state_q <= state_d;
    end

    // scaled references against the configured maxima
    ref_scaler u_ref1 (
        .word_in(ref1_q),
        .full_scale(primary_setpoint_full_scale),
        .floor_mag(setpoint_floor),
        .floor_en(setpoint_floor_en),
        .word_out(ref1_scaled)
    );
    ref_scaler u_ref2 (
        .word_in(ref2_q),
        .full_scale(secondary_setpoint_full_scale),
        .floor_mag(setpoint_floor),
        .floor_en(setpoint_floor_en),
        .word_out(ref2_scaled)
    );

    // ramp output walks toward the reference, stepping down in ramp and quick stop, dropping at once in coast stop
    always_comb begin
        ramp_d = ramp_q;
        case (state_q)
            st_coast_stop, st_fault: ramp_d = 16'h0000; // coast drops torque at once
            st_quick_stop: begin
                ramp_d = (ramp_q > `QUICK_STOP_STEP) ? ramp_q - `QUICK_STOP_STEP : 16'h0000;
            end
            st_ramp_stop: begin
                ramp_d = (ramp_q != 16'h0000) ? ramp_q - `RAMP_STOP_STEP : 16'h0000;
            end
            st_op_en: begin
                if (!cmd_q[`CMD_RAMP_OUT_BIT]) begin
                    // forced to zero, ramp down so current limits hold
                    ramp_d = (ramp_q != 16'h0000) ? ramp_q - `RAMP_STOP_STEP : 16'h0000;
                end else if (ramp_q < ref1_scaled) begin
                    ramp_d = ramp_q + `RAMP_STOP_STEP;
                end else if (ramp_q > ref1_scaled) begin
                    ramp_d = ramp_q - `RAMP_STOP_STEP;
                end
            end
            default: ramp_d = 16'h0000; // inhibited states hold no output
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) ramp_q <= 16'h0000;
        else ramp_q <= ramp_d;
    end

    // status word from state, with the coast and quick stop off bits taken from the command word
    always_comb begin
        status_d = 16'h0000;
        status_d[`STS_RDY_ON_BIT] = (state_q == st_rdy_on) || (state_q == st_rdy_run) ||
                                    (state_q == st_op_en);
        status_d[`STS_RDY_RUN_BIT] = (state_q == st_rdy_run) || (state_q == st_op_en);
        status_d[`STS_OP_EN_BIT] = (state_q == st_op_en);
        status_d[`STS_FAULT_BIT] = (state_q == st_fault);
        status_d[`STS_COAST_OFF_BIT] = ~stop_req(cmd_q, `CMD_COAST_STOP_BIT);
        status_d[`STS_QUICK_OFF_BIT] = ~stop_req(cmd_q, `CMD_QUICK_STOP_BIT);
        status_d[`STS_INHIBIT_BIT] = (state_q == st_inhibit);
    end

    // actual value quantity selected by configuration
    always_comb begin
        case (actual_sel)
            2'h0: actual_d_w = actual_a;
            2'h1: actual_d_w = actual_b;
            2'h2: actual_d_w = actual_c;
            default: actual_d_w = actual_d;
        endcase
    end

    // profile handling: convert in standard, forward in pass-through
    always_comb begin
        case (profile_sel)
            prof_std: native_d = '{cmd: cmd_q, ref1: ref1_scaled, ref2: ref2_scaled};
            prof_pass16, prof_pass32: native_d = '{cmd: cmd_q, ref1: ref1_q, ref2: ref2_q};
            default: native_d = '{cmd: cmd_q, ref1: ref1_q, ref2: ref2_q};
        endcase
    end

    // registered outputs
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            drive_native_format <= '0;
            status_word <= 16'h0000;
            actual_word <= 16'h0000;
            map_active <= 2'h0;
            ramp_out <= 16'h0000;
            ramp_stop_cmd <= 1'b0;
            coast_stop_cmd <= 1'b0;
            quick_stop_cmd <= 1'b0;
        end else begin
            drive_native_format <= native_d;
            // standard profile returns own status, pass-through the drive's
            status_word <= (profile_sel == prof_std) ? status_d : drive_native_in.status;
            actual_word <= (profile_sel == prof_std) ? actual_d_w : drive_native_in.act1;
            map_active <= map_sel;
            ramp_out <= ramp_q;
            ramp_stop_cmd <= (state_q == st_ramp_stop);
            coast_stop_cmd <= (state_q == st_coast_stop);
            quick_stop_cmd <= (state_q == st_quick_stop);
        end
    end
endmodule : drive_control_word_decoder
`default_nettype wire

//--- rtl/ref_scaler.sv
`timescale 1ns/1ps
`default_nettype none
// signed linear scaling of a 16-bit word against a full-scale value
module ref_scaler (
    input wire logic [15:0] word_in,
    input wire logic [15:0] full_scale,
    input wire logic [15:0] floor_mag,
    input wire logic floor_en,
    output logic [15:0] word_out
);
    logic neg;
    logic [14:0] mag;
    logic [30:0] prod;
    logic [15:0] scaled;
    logic [15:0] clamped;

    // sign plus 15-bit magnitude; negatives arrive as two's complement
    assign neg = word_in[15];
    assign mag = neg ? 15'(-word_in) : word_in[14:0];
    // magnitude times full scale over 2^14 keeps 20000-style spans linear
    assign prod = 31'(mag) * 31'(full_scale[14:0]);
    // spans above 0x4000 can carry past 15 bits; saturate rather than wrap the sign
    assign scaled = prod[29] ? 16'h7FFF : {1'b0, prod[28:14]};
    // minimum reference clamp only applies on magnitude
    assign clamped = (floor_en && mag != 15'h0000 && scaled < floor_mag) ? floor_mag : scaled;
    assign word_out = neg ? 16'(-clamped) : clamped;
endmodule : ref_scaler
`default_nettype wire

//--- shared/dcw_defs.svh
`ifndef DCW_DEFS_SVH
`define DCW_DEFS_SVH

// command word bit positions
`define CMD_RAMP_STOP_BIT 0
`define CMD_COAST_STOP_BIT 1
`define CMD_QUICK_STOP_BIT 2
`define CMD_RUN_PERMIT_BIT 3
`define CMD_RAMP_OUT_BIT 4
`define CMD_FAULT_RESET_BIT 7
// status word bit positions
`define STS_RDY_ON_BIT 0
`define STS_RDY_RUN_BIT 1
`define STS_OP_EN_BIT 2
`define STS_FAULT_BIT 3
`define STS_COAST_OFF_BIT 4
`define STS_QUICK_OFF_BIT 5
`define STS_INHIBIT_BIT 6
// reset values
`define CMD_WORD_RESET 16'h0000
// stop timing, deceleration step per clock on the ramp output
`define QUICK_STOP_STEP 16'h0010
`define RAMP_STOP_STEP 16'h0001
// profile selector encodings
`define PROFILE_STD 2'h0
`define PROFILE_PASS16 2'h1
`define PROFILE_PASS32 2'h2

`endif

//--- shared/dcw_pkg.sv
`default_nettype none
package dcw_pkg;
    typedef enum logic [1:0] {
        prof_std,
        prof_pass16,
        prof_pass32,
        prof_rsvd
    } profile_t;

    // three words handed to and from the drive core
    typedef struct packed {
        logic [15:0] cmd;
        logic [15:0] ref1;
        logic [15:0] ref2;
    } drive_out_t;

    typedef struct packed {
        logic [15:0] status;
        logic [15:0] act1;
        logic [15:0] act2;
    } drive_in_t;
endpackage : dcw_pkg
`default_nettype wire

//--- tb/dcw_checker_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module dcw_checker (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic cmd_wr,
    input wire logic [15:0] cmd_wdata,
    input wire dcw_pkg::profile_t profile_sel,
    input wire logic [1:0] map_sel,
    input wire logic fault_in,
    input wire logic [15:0] status_word,
    input wire logic [15:0] ramp_out,
    input wire logic [1:0] map_active,
    input wire logic ramp_stop_cmd,
    input wire logic coast_stop_cmd,
    input wire logic quick_stop_cmd
);
    import dcw_pkg::*;
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    // stops judged only from a running drive; pass-through status is not ours
    logic std_w;
    logic run_w;
    assign std_w = (profile_sel == prof_std);
    assign run_w = std_w && status_word[2] && cmd_wr;
    a_ramp_stop: assert property (run_w && cmd_wdata[2:0] == 3'h6 |-> ##[1:3] ramp_stop_cmd)
        else $error("ramp stop not raised");
    a_coast_stop: assert property (run_w && !cmd_wdata[1] |-> ##[1:3] coast_stop_cmd)
        else $error("coast stop not raised");
    a_quick_stop: assert property (run_w && cmd_wdata[2:1] == 2'h1 |-> ##[1:3] quick_stop_cmd)
        else $error("quick stop not raised");
    a_coast_zero: assert property ($rose(coast_stop_cmd) |-> ##[0:2] ramp_out == 16'h0000)
        else $error("coast left ramp output running");
    a_fault_flag: assert property (std_w && $rose(fault_in) |-> ##[2:6] status_word[3])
        else $error("fault not reported");
    a_fault_wins: assert property (std_w && status_word[3] |-> status_word[2:0] == 3'h0)
        else $error("ready bits set during fault");
    a_inhibit_idle: assert property (std_w && status_word[6] |-> status_word[2:0] == 3'h0)
        else $error("ready bits set while inhibited");
    a_map_echo: assert property (map_active == $past(map_sel))
        else $error("map selection not presented");
endmodule : dcw_checker
bind drive_control_word_decoder dcw_checker chk_u (
    .core_clk, .rst_n, .cmd_wr, .cmd_wdata, .profile_sel, .map_sel, .fault_in, .status_word,
    .ramp_out, .map_active, .ramp_stop_cmd, .coast_stop_cmd, .quick_stop_cmd
);
`default_nettype wire

//--- tb/drive_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module drive_core_model (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic fault_req,
    input wire dcw_pkg::drive_out_t drive_native_format,
    output logic fault_in,
    output logic [15:0] actual_a,
    output logic [15:0] actual_b,
    output logic [15:0] actual_c,
    output logic [15:0] actual_d,
    output dcw_pkg::drive_in_t drive_native_in
);
    import dcw_pkg::*;
    // one fixed quantity per selector code
    assign actual_a = 16'hA001;
    assign actual_b = 16'hB002;
    assign actual_c = 16'hC003;
    assign actual_d = 16'hD004;
    // drive answers a clock late, so the block cannot rely on same-cycle echo
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            drive_native_in <= '0;
            fault_in <= 1'b0;
        end else begin
            drive_native_in.status <= drive_native_format.cmd[0] ? 16'h0237 : 16'h0250;
            drive_native_in.act1 <= drive_native_format.ref1;
            drive_native_in.act2 <= drive_native_format.ref2;
            fault_in <= fault_req;
        end
    end
endmodule : drive_core_model
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import dcw_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic cmd_wr = 1'b0, ref1_wr = 1'b0, ref2_wr = 1'b0, fault_req = 1'b0, fault_in;
    logic run_permit_from_bus = 1'b1, run_permit_ext = 1'b0, setpoint_floor_en = 1'b0;
    logic ramp_stop_cmd, coast_stop_cmd, quick_stop_cmd;
    logic [1:0] map_sel = 2'h0, actual_sel = 2'h0, map_active;
    logic [15:0] cmd_wdata = '0, ref1_wdata = '0, ref2_wdata = '0, setpoint_floor = '0;
    logic [15:0] primary_setpoint_full_scale = 16'h4000;
    logic [15:0] secondary_setpoint_full_scale = 16'h2000;
    logic [15:0] actual_a, actual_b, actual_c, actual_d, status_word, actual_word, ramp_out;
    profile_t profile_sel = prof_std;
    drive_in_t drive_native_in;
    drive_out_t drive_native_format;
    int bad_count = 0;
    int samples_checked = 0;

    drive_control_word_decoder dut_u (
        .core_clk, .rst_n, .cmd_wr, .cmd_wdata, .ref1_wr, .ref1_wdata, .ref2_wr, .ref2_wdata,
        .profile_sel, .map_sel, .run_permit_from_bus, .run_permit_ext,
        .primary_setpoint_full_scale, .secondary_setpoint_full_scale, .setpoint_floor,
        .setpoint_floor_en, .actual_sel, .fault_in, .actual_a, .actual_b, .actual_c,
        .actual_d, .drive_native_in, .drive_native_format, .status_word, .actual_word,
        .ramp_out, .map_active, .ramp_stop_cmd, .coast_stop_cmd, .quick_stop_cmd
    );
    drive_core_model core_u (
        .core_clk, .rst_n, .fault_req, .drive_native_format, .fault_in, .actual_a,
        .actual_b, .actual_c, .actual_d, .drive_native_in
    );

    // 200 mhz core clock
    initial begin
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic conclude();
        if (bad_count == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // one strobe cycle: 0 command, 1 primary, 2 secondary setpoint
    task automatic wr(input int w, input logic [15:0] d);
        @(posedge core_clk);
        cmd_wr <= (w == 0);
        ref1_wr <= (w == 1);
        ref2_wr <= (w == 2);
        cmd_wdata <= d;
        ref1_wdata <= d;
        ref2_wdata <= d;
        @(posedge core_clk);
        cmd_wr <= 1'b0;
        ref1_wr <= 1'b0;
        ref2_wr <= 1'b0;
    endtask : wr

    // outputs land up to three edges after the write
    task automatic settle();
        repeat (3) @(posedge core_clk);
        #1;
    endtask : settle

    function automatic logic [15:0] pick(input int k);
        return (k == 0) ? status_word : ramp_out;
    endfunction : pick

    // bounded poll; running out ends the run at once
    task automatic wt(input string nm, input int k, input logic [15:0] e,
                      input logic [15:0] m, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge core_clk);
            #1;
            if ((pick(k) & m) === e) begin
                break;
            end
        end
        chk(nm, pick(k) & m, e);
        if ((pick(k) & m) !== e) begin
            conclude();
        end
    endtask : wt

    task automatic ref_case(input int w, input logic [15:0] d, input logic [15:0] e);
        wr(w, d);
        settle();
        chk("setpoint", (w == 1) ? drive_native_format.ref1 : drive_native_format.ref2, e);
    endtask : ref_case

    // main sequence
    initial begin
        repeat (11) @(posedge core_clk);
        #1;
        chk("rst_status", status_word, 16'h0000);
        chk("rst_ramp", ramp_out, 16'h0000);
        @(posedge core_clk);
        rst_n <= 1'b1;
        map_sel <= 2'h2;
        wt("idle", 0, 16'h0040, 16'hFFFF, 8);
        chk("map", {14'h0, map_active}, 16'h0002);
        ref_case(1, 16'h1234, 16'h1234);
        ref_case(1, 16'hEDCC, 16'hEDCC);
        ref_case(2, 16'h1000, 16'h0800);
        ref_case(2, 16'hF000, 16'hF800);
        @(posedge core_clk);
        setpoint_floor <= 16'h0100;
        setpoint_floor_en <= 1'b1;
        ref_case(1, 16'h0010, 16'h0100);
        @(posedge core_clk);
        setpoint_floor_en <= 1'b0;
        ref_case(1, 16'h0040, 16'h0040);
        wr(0, 16'h0006);
        wt("rdy_on", 0, 16'h0031, 16'hFFFF, 8);
        wr(0, 16'h000F);
        wt("op_en", 0, 16'h0037, 16'hFFFF, 8);
        wr(0, 16'h001F);
        wt("ramp_up", 1, 16'h0040, 16'hFFFF, 300);
        wr(0, 16'h000F);
        wt("ramp_zero", 1, 16'h0000, 16'hFFFF, 300);
        wr(0, 16'h000E);
        wt("ramp_stop", 0, 16'h0031, 16'hFFFF, 300);
        wr(0, 16'h000F);
        wt("op_en2", 0, 16'h0037, 16'hFFFF, 8);
        wr(0, 16'h000B);
        wt("quick", 0, 16'h0050, 16'hFFFF, 300);
        @(posedge core_clk);
        run_permit_from_bus <= 1'b0;
        wr(0, 16'h0006);
        wt("rdy_on2", 0, 16'h0031, 16'hFFFF, 8);
        wr(0, 16'h000F);
        settle();
        chk("no_permit", status_word, 16'h0033);
        @(posedge core_clk);
        run_permit_ext <= 1'b1;
        wt("ext_permit", 0, 16'h0037, 16'hFFFF, 8);
        wr(0, 16'h000D);
        wt("coast", 0, 16'h0060, 16'hFFFF, 20);
        chk("coast_ramp", ramp_out, 16'h0000);
        @(posedge core_clk);
        fault_req <= 1'b1;
        wt("fault", 0, 16'h0008, 16'h000F, 10);
        @(posedge core_clk);
        fault_req <= 1'b0;
        wr(0, 16'h0000);
        settle();
        chk("fault_held", status_word & 16'h000F, 16'h0008);
        wr(0, 16'h0080);
        wt("fault_clr", 0, 16'h0040, 16'hFFFF, 10);
        for (int k = 0; k < 4; k++) begin
            @(posedge core_clk);
            actual_sel <= k[1:0];
            settle();
            chk("actual", actual_word, 16'hA001 + 16'h1001 * k[15:0]);
        end
        // code 3 is decoded as pass-through as well
        for (int p = 1; p < 4; p++) begin
            @(posedge core_clk);
            profile_sel <= profile_t'(p);
            wr(0, 16'h1233 + p[15:0]);
            wr(1, 16'h8765);
            settle();
            chk("pass_cmd", drive_native_format.cmd, 16'h1233 + p[15:0]);
            chk("pass_ref", drive_native_format.ref1, 16'h8765);
            chk("pass_act", actual_word, 16'h8765);
            chk("pass_sts", status_word, p[0] ? 16'h0250 : 16'h0237);
        end
        conclude();
    end
endmodule : testbench
`default_nettype wire
